// file: logic/phy_pm_pkg.sv
package phy_pm_pkg;

  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned REFRESH_TIME_US = 200;
  localparam int unsigned REFRESH_PERIOD_MS = 20;
  localparam int unsigned LINK_PULSE_PERIOD_MS = 16;
  localparam int unsigned WAKE_1000_US = 16;
  localparam int unsigned WAKE_100_US = 30;
  localparam int unsigned LPI_HOLD_GTX_CYCLES = 10;
  localparam int unsigned REFRESH_CYCLES = (REFRESH_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned REFRESH_PERIOD_CYCLES = (REFRESH_PERIOD_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned LINK_PULSE_CYCLES = (LINK_PULSE_PERIOD_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_1000_CYCLES = (WAKE_1000_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_100_CYCLES = (WAKE_100_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W = 22;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] EEE_ADV_ADDR = 8'h04;
  localparam logic [7:0] SLEEP_CFG_ADDR = 8'h08;
  localparam logic [7:0] TEN_TE_ADDR = 8'h0C;
  localparam logic [7:0] STATUS_ADDR = 8'h10;

  // ==========================================================
  // field positions
  localparam int unsigned CTRL_SPEED_BIT = 6;
  localparam int unsigned CTRL_RESTART_AN_BIT = 9;
  localparam int unsigned CTRL_SOFT_PD_BIT = 11;
  localparam int unsigned CTRL_AN_EN_BIT = 12;
  localparam int unsigned ADV_100_BIT = 1;
  localparam int unsigned ADV_1000_BIT = 2;
  localparam int unsigned SLEEP_EN_BIT = 0;
  localparam int unsigned TEN_TE_BIT = 10;

  // ==========================================================
  // reset values and codes
  localparam logic [31:0] CTRL_RESET = 32'h0000_1040;
  localparam logic [3:0] STRAP_CHIP_PD = 4'h7;
  localparam logic [3:0] LPI_TXD_LO = 4'h1;
  localparam logic [3:0] LPI_TXD_HI = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    TX_NORMAL = 3'b001,
    TX_LPI_QUIET = 3'b010,
    TX_LPI_REFRESH = 3'b100
  } tx_lpi_state_t;

  // one sampled transmit symbol
  typedef struct packed {
    logic tx_en;
    logic tx_er;
    logic [7:0] txd;
  } tx_symbol_t;

endpackage : phy_pm_pkg

// file: logic/phy_power_mgmt_eee_tx_lpi.sv
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
// Notes on behaviour
// R1: strap code 0111 caught after reset forces chip power-down.
// R2: chip power-down ends only through reset with another strap code.
// R3: control bit 11 set puts block in soft power-down; registers stay reachable.
// R4: clearing control bit 11 leaves soft power-down.
// R5: sleep enable bit acts only with autonegotiation on and no link.
// R6: in energy-detect sleep only periodic link pulses and detection stay alive; sleep here does not stop the transmit path or ten_te_out.
// R7: energy-detect sleep enable is off after reset.
// R8: EEE off by default; enabled by advertisement bits 2 and 1.
// R9: software restarts autonegotiation via control bit 9 to apply advertisement.
// R10: bit 10 of the 10Base-Te register enables reduced amplitude.
// R11: transmit and receive low-power idle are tracked separately.
// R12: in low-power idle a 200 us refresh repeats every 20 ms.
// R13: any traffic leaves low-power idle at once, within wake limits.
// R14: gigabit: enable and data low on rise, error and high nibble on fall.
// R15: 100 Mbps: enable and low nibble on rise, error on fall.
// R16: gigabit idle code: enable low, error high, data 01h.
// R17: 100 Mbps idle code: enable low, error high, low nibble 1.
// R18: idle held while pattern holds; any departure exits.
// R19: MAC stops link clock only after ten cycles of idle code.
// R20: idle state survives a stopped link clock; exit seen at restart.
module phy_power_mgmt_eee_tx_lpi
  import phy_pm_pkg::*;
#(
  parameter int unsigned REFRESH_LEN = REFRESH_CYCLES,
  parameter int unsigned REFRESH_PERIOD = REFRESH_PERIOD_CYCLES,
  parameter int unsigned LINK_PULSE_PERIOD = LINK_PULSE_CYCLES
)
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // straps and line status
  input wire logic [3:0] mode_strap_in,
  input wire logic link_up_in,
  input wire logic rx_lpi_in,
  // rgmii transmit pins
  input wire logic gtx_clk_in,
  input wire logic tx_ctl_in,
  input wire logic [3:0] txd_in,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // power state
  output logic chip_powerdown_out,
  output logic soft_powerdown_out,
  output logic energy_detect_sleep_out,
  output logic link_pulse_out,
  output logic ten_te_out,
  output logic an_restart_out,
  output logic [1:0] eee_active_out,
  // low-power idle
  output logic tx_lpi_out,
  output logic rx_lpi_out,
  output logic refresh_out,
  output logic clk_stop_ok_out,
  output logic [9:0] tx_symbol_out
);

  // ==========================================================
  // helpers
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge_bytes

  function automatic logic is_mapped(input logic [7:0] a);
    logic r;
    if (a == CTRL_ADDR) begin
      r = 1'b1;
    end else if (a == EEE_ADV_ADDR || a == SLEEP_CFG_ADDR) begin
      r = 1'b1;
    end else if (a == TEN_TE_ADDR || a == STATUS_ADDR) begin
      r = 1'b1;
    end else begin
      r = 1'b0;
    end
    return r;
  endfunction : is_mapped

  // ==========================================================
  // declarations
  logic [31:0] ctrl_q;
  logic [31:0] eee_adv_q;
  logic sleep_en_q;
  logic ten_te_q;
  logic [1:0] eee_active_q;
  logic adv_pending_q;
  logic an_restart_q;
  logic chip_pd_q;
  logic strap_taken_q;
  logic [7:0] strap_sync_q;
  logic [1:0] rx_meta_q;
  logic [1:0] link_meta_q;
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic [31:0] status_w;
  logic sleep_active;
  logic pd_any;
  logic [TIMER_W-1:0] pulse_cnt_q;
  logic [TIMER_W-1:0] lpi_cnt_q;
  logic [3:0] hold_cnt_q;
  tx_lpi_state_t tx_state_q;
  logic rise_ok_seen_q;
  logic s_rise;
  logic s_fall;
  logic s_rise_ok;
  logic s_fall_ok;
  tx_symbol_t s_symbol;
  logic speed_1000;
  logic eee_speed_ok;

  rgmii_tx_sampler u_sampler (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .gtx_clk_in(gtx_clk_in),
    .tx_ctl_in(tx_ctl_in),
    .txd_in(txd_in),
    .rise_out(s_rise),
    .fall_out(s_fall),
    .rise_ok_out(s_rise_ok),
    .fall_ok_out(s_fall_ok),
    .symbol_out(s_symbol)
  );

  // ==========================================================
  // axi4-lite slave
  assign wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= s_axi_awvalid & ~aw_have_q & ~s_axi_awready;
      s_axi_wready <= s_axi_wvalid & ~w_have_q & ~s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (is_mapped(awaddr_q) && awaddr_q != STATUS_ADDR) ?
                       RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        if (s_axi_araddr == CTRL_ADDR) begin
          s_axi_rdata <= ctrl_q;
        end else if (s_axi_araddr == EEE_ADV_ADDR) begin
          s_axi_rdata <= eee_adv_q;
        end else if (s_axi_araddr == SLEEP_CFG_ADDR) begin
          s_axi_rdata <= {31'h0000_0000, sleep_en_q};
        end else if (s_axi_araddr == TEN_TE_ADDR) begin
          s_axi_rdata <= {21'h00_0000, ten_te_q, 10'h000};
        end else if (s_axi_araddr == STATUS_ADDR) begin
          s_axi_rdata <= status_w;
        end else begin
          s_axi_rdata <= 32'h0000_0000;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // configuration registers; stay writable in soft power-down
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_q <= CTRL_RESET;
      eee_adv_q <= 32'h0000_0000; // see R8
      sleep_en_q <= 1'b0; // see R7
      ten_te_q <= 1'b0;
      adv_pending_q <= 1'b0;
    end else begin
      if (wr_fire && awaddr_q == CTRL_ADDR) begin
        ctrl_q <= merge_bytes(ctrl_q, wdata_q, wstrb_q); // see R3 see R4
      end else begin
        ctrl_q[CTRL_RESTART_AN_BIT] <= 1'b0;
      end
      if (wr_fire && awaddr_q == EEE_ADV_ADDR) begin
        eee_adv_q <= merge_bytes(eee_adv_q, wdata_q, wstrb_q) & 32'h0000_0006;
        adv_pending_q <= 1'b1;
      end else if (an_restart_q) begin
        adv_pending_q <= 1'b0;
      end
      if (wr_fire && awaddr_q == SLEEP_CFG_ADDR && wstrb_q[0]) begin
        sleep_en_q <= wdata_q[SLEEP_EN_BIT]; // see R5
      end
      if (wr_fire && awaddr_q == TEN_TE_ADDR && wstrb_q[1]) begin
        ten_te_q <= wdata_q[TEN_TE_BIT]; // see R10
      end
    end
  end

  // advertisement applies only once autonegotiation restarts
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      an_restart_q <= 1'b0;
      eee_active_q <= 2'b00;
    end else begin
      an_restart_q <= ctrl_q[CTRL_RESTART_AN_BIT] & ~pd_any;
      if (an_restart_q) begin
        eee_active_q <= {eee_adv_q[ADV_1000_BIT], eee_adv_q[ADV_100_BIT]}; // see R9
      end
    end
  end

  // ==========================================================
  // straps and power-down
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      strap_taken_q <= 1'b0;
      chip_pd_q <= 1'b0;
    end else if (!strap_taken_q) begin
      strap_taken_q <= 1'b1;
      chip_pd_q <= (strap_sync_q[7:4] == STRAP_CHIP_PD); // see R1
    end
  end
  // no path clears chip_pd_q except the reset itself; see R2

  // static pins: no reset, so the stages fill while reset is held
  always_ff @(posedge mclk_in) begin
    strap_sync_q <= {strap_sync_q[3:0], mode_strap_in};
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_meta_q <= 2'b00;
      link_meta_q <= 2'b00;
    end else begin
      rx_meta_q <= {rx_meta_q[0], rx_lpi_in};
      link_meta_q <= {link_meta_q[0], link_up_in};
    end
  end

  assign pd_any = chip_pd_q | ctrl_q[CTRL_SOFT_PD_BIT] | ~strap_taken_q; // see R3
  assign sleep_active = sleep_en_q & ctrl_q[CTRL_AN_EN_BIT] & ~link_meta_q[1] & ~pd_any; // see R5
  assign speed_1000 = ctrl_q[CTRL_SPEED_BIT];
  assign eee_speed_ok = speed_1000 ? eee_active_q[1] : eee_active_q[0];

  // ==========================================================
  // energy-detect sleep link pulses; interval is a trade of
  // wake latency against power
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pulse_cnt_q <= '0;
      link_pulse_out <= 1'b0;
    end else begin
      link_pulse_out <= 1'b0;
      if (!sleep_active) begin
        pulse_cnt_q <= '0;
      end else if (pulse_cnt_q == TIMER_W'(LINK_PULSE_PERIOD - 1)) begin
        pulse_cnt_q <= '0;
        link_pulse_out <= 1'b1; // see R6
      end else begin
        pulse_cnt_q <= pulse_cnt_q + 1'b1;
      end
    end
  end

  // ==========================================================
  // transmit low-power idle
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_state_q <= TX_NORMAL;
      rise_ok_seen_q <= 1'b0;
      lpi_cnt_q <= '0;
    end else begin
      if (s_rise) begin
        rise_ok_seen_q <= s_rise_ok;
      end
      case (tx_state_q)
        TX_NORMAL: begin
          lpi_cnt_q <= '0;
          if (eee_speed_ok && !pd_any && s_fall && s_fall_ok && rise_ok_seen_q) begin
            // 100 Mbps ignores the high nibble
            tx_state_q <= TX_LPI_REFRESH; // see R16 see R17
          end else if (eee_speed_ok && !pd_any && !speed_1000 && s_fall && rise_ok_seen_q
                       && s_symbol.tx_er == 1'b1 && !s_symbol.tx_en) begin
            tx_state_q <= TX_LPI_REFRESH; // see R17
          end
        end
        TX_LPI_REFRESH: begin
          if (pd_any || (s_rise && !s_rise_ok) ||
              (s_fall && !s_fall_ok && (speed_1000 || !s_symbol.tx_er))) begin
            tx_state_q <= TX_NORMAL; // see R13 see R18
          end else if (lpi_cnt_q == TIMER_W'(REFRESH_LEN - 1)) begin
            lpi_cnt_q <= lpi_cnt_q + 1'b1;
            tx_state_q <= TX_LPI_QUIET; // see R12
          end else begin
            lpi_cnt_q <= lpi_cnt_q + 1'b1;
          end
        end
        TX_LPI_QUIET: begin
          // no edge while the link clock is stopped: idle holds and the refresh cycle runs on, see R20
          if (pd_any || (s_rise && !s_rise_ok) ||
              (s_fall && !s_fall_ok && (speed_1000 || !s_symbol.tx_er))) begin
            tx_state_q <= TX_NORMAL; // see R13 see R18
          end else if (lpi_cnt_q == TIMER_W'(REFRESH_PERIOD - 1)) begin
            lpi_cnt_q <= '0;
            tx_state_q <= TX_LPI_REFRESH; // see R12
          end else begin
            lpi_cnt_q <= lpi_cnt_q + 1'b1;
          end
        end
        default: begin
          tx_state_q <= TX_NORMAL;
        end
      endcase
    end
  end

  // counts link cycles in idle so software can see when clock stop is legal
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hold_cnt_q <= 4'h0;
    end else if (tx_state_q == TX_NORMAL) begin
      hold_cnt_q <= 4'h0;
    end else if (s_rise && hold_cnt_q != 4'(LPI_HOLD_GTX_CYCLES)) begin
      hold_cnt_q <= hold_cnt_q + 4'h1; // see R19
    end
  end

  // ==========================================================
  // outputs, all registered
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      chip_powerdown_out <= 1'b0;
      soft_powerdown_out <= 1'b0;
      energy_detect_sleep_out <= 1'b0;
      ten_te_out <= 1'b0;
      an_restart_out <= 1'b0;
      eee_active_out <= 2'b00;
      tx_lpi_out <= 1'b0;
      rx_lpi_out <= 1'b0;
      refresh_out <= 1'b0;
      clk_stop_ok_out <= 1'b0;
      tx_symbol_out <= 10'h000;
    end else begin
      chip_powerdown_out <= chip_pd_q;
      soft_powerdown_out <= ctrl_q[CTRL_SOFT_PD_BIT] & ~chip_pd_q;
      energy_detect_sleep_out <= sleep_active;
      ten_te_out <= ten_te_q & ~pd_any;
      an_restart_out <= an_restart_q;
      eee_active_out <= eee_active_q;
      tx_lpi_out <= (tx_state_q != TX_NORMAL);
      rx_lpi_out <= rx_meta_q[1] & |eee_active_q & ~pd_any; // see R11
      refresh_out <= (tx_state_q == TX_LPI_REFRESH);
      clk_stop_ok_out <= (hold_cnt_q == 4'(LPI_HOLD_GTX_CYCLES));
      tx_symbol_out <= pd_any ? 10'h000 :
                       {s_symbol.tx_en, s_symbol.tx_er,
                        speed_1000 ? s_symbol.txd : {4'h0, s_symbol.txd[3:0]}}; // see R15
    end
  end

  assign status_w = {24'h00_0000, adv_pending_q, clk_stop_ok_out, refresh_out,
                     rx_lpi_out, tx_lpi_out, sleep_active, soft_powerdown_out,
                     chip_powerdown_out};

endmodule : phy_power_mgmt_eee_tx_lpi

// file: logic/rgmii_tx_sampler.sv
`timescale 1ns/1ps
module rgmii_tx_sampler
  import phy_pm_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // rgmii transmit pins
  input wire logic gtx_clk_in,
  input wire logic tx_ctl_in,
  input wire logic [3:0] txd_in,
  // sampled view
  output logic rise_out,
  output logic fall_out,
  output logic rise_ok_out,
  output logic fall_ok_out,
  output tx_symbol_t symbol_out
);

  // ==========================================================
  // two-stage synchronisers
  logic [5:0] meta_q;
  logic [5:0] sync_q;
  logic clk_prev_q;

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_q <= 6'h00;
      sync_q <= 6'h00;
      clk_prev_q <= 1'b0;
    end else begin
      meta_q <= {gtx_clk_in, tx_ctl_in, txd_in};
      sync_q <= meta_q;
      clk_prev_q <= sync_q[5];
    end
  end

  // ==========================================================
  // edge capture; data is stable for half a link period so
  // the shared latency keeps clock and data aligned
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rise_out <= 1'b0;
      fall_out <= 1'b0;
      rise_ok_out <= 1'b0;
      fall_ok_out <= 1'b0;
      symbol_out <= '0;
    end else begin
      rise_out <= sync_q[5] & ~clk_prev_q;
      fall_out <= ~sync_q[5] & clk_prev_q;
      if (sync_q[5] && !clk_prev_q) begin
        symbol_out.tx_en <= sync_q[4]; // see R14 see R15
        symbol_out.txd[3:0] <= sync_q[3:0];
        rise_ok_out <= ~sync_q[4] & (sync_q[3:0] == LPI_TXD_LO); // see R16 see R17
      end
      if (!sync_q[5] && clk_prev_q) begin
        symbol_out.tx_er <= sync_q[4] ^ symbol_out.tx_en; // see R14
        symbol_out.txd[7:4] <= sync_q[3:0];
        fall_ok_out <= (sync_q[4] ^ symbol_out.tx_en) & (sync_q[3:0] == LPI_TXD_HI);
      end
    end
  end

endmodule : rgmii_tx_sampler

// file: testbench/phy_pm_asserts.sv
`timescale 1ns/1ps
module phy_pm_asserts
  import phy_pm_pkg::*;
#(
  parameter int unsigned REFRESH_LEN = REFRESH_CYCLES
)
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // watched outputs
  input wire logic chip_powerdown_out,
  input wire logic soft_powerdown_out,
  input wire logic energy_detect_sleep_out,
  input wire logic link_pulse_out,
  input wire logic ten_te_out,
  input wire logic an_restart_out,
  input wire logic tx_lpi_out,
  input wire logic refresh_out,
  input wire logic clk_stop_ok_out,
  input wire logic [9:0] tx_symbol_out
);
  // ==========================================================
  // burst length counter
  logic [31:0] burst_q;
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      burst_q <= 32'h0;
    end else begin
      burst_q <= refresh_out ? burst_q + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  // ==========================================================
  // properties
  a_chip_pd_excl: assert property (chip_powerdown_out |-> !soft_powerdown_out)
    else $error("soft pd in chip pd");
  a_chip_pd_hold: assert property (!$fell(chip_powerdown_out))
    else $error("chip pd left without reset");
  a_chip_pd_quiet: assert property (chip_powerdown_out |-> !tx_lpi_out && !ten_te_out
    && tx_symbol_out == 10'h000) else $error("activity in chip pd");
  a_soft_pd_quiet: assert property (soft_powerdown_out[*3] |-> !tx_lpi_out && !ten_te_out)
    else $error("activity in soft pd");
  a_sleep_pd: assert property (soft_powerdown_out[*2] |-> !energy_detect_sleep_out)
    else $error("sleep in soft pd");
  a_pulse_sleep: assert property (link_pulse_out |-> $past(energy_detect_sleep_out))
    else $error("pulse outside sleep");
  a_pulse_once: assert property (link_pulse_out |=> !link_pulse_out)
    else $error("pulse too long");
  a_restart_once: assert property (an_restart_out |=> !an_restart_out)
    else $error("restart too long");
  a_refresh_lpi: assert property ($rose(refresh_out) |-> ##[0:2] tx_lpi_out)
    else $error("refresh outside idle");
  a_refresh_len: assert property ($fell(refresh_out) && tx_lpi_out |->
    burst_q == REFRESH_LEN) else $error("refresh length wrong");
  a_stop_ok_lpi: assert property (clk_stop_ok_out |-> tx_lpi_out || $past(tx_lpi_out))
    else $error("clock stop outside idle");
  a_stop_ok_late: assert property ($rose(tx_lpi_out) |-> !clk_stop_ok_out[*8])
    else $error("clock stop too early");
  c_lpi: cover property ($rose(tx_lpi_out));
  c_refresh: cover property ($fell(refresh_out) && tx_lpi_out);
  c_pulse: cover property (link_pulse_out);
endmodule : phy_pm_asserts

bind phy_power_mgmt_eee_tx_lpi phy_pm_asserts #(.REFRESH_LEN(REFRESH_LEN)) i_phy_pm_asserts (.*);

// file: testbench/phy_power_mgmt_eee_tx_lpi_bench.sv
`timescale 1ns/1ps
module phy_power_mgmt_eee_tx_lpi_bench;
  import phy_pm_pkg::*;
  localparam int RL = 20;
  localparam int RP = 200;
  localparam int LP = 50;
  logic mclk_in = 1'h0;
  logic reset_n_in = 1'h0;
  logic [3:0] mode_strap_in = 4'h0;
  logic link_up_in = 1'h0;
  logic rx_lpi_in = 1'h0;
  wire gtx_clk_in, tx_ctl_in;
  wire [3:0] txd_in;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, eee_active_out;
  logic [31:0] s_axi_rdata;
  logic chip_powerdown_out, soft_powerdown_out, energy_detect_sleep_out, link_pulse_out;
  logic ten_te_out, an_restart_out, tx_lpi_out, rx_lpi_out, refresh_out, clk_stop_ok_out;
  logic [9:0] tx_symbol_out, v;
  logic [31:0] sh [4];
  logic [15:0] rnd = 16'h8FBE;
  int err_total = 0, samples_checked = 0, cyc = 0, n;
  bit m_chp, m_sft, m_slp, m_te, m_tx, m_rx;

  phy_power_mgmt_eee_tx_lpi #(.REFRESH_LEN(RL), .REFRESH_PERIOD(RP), .LINK_PULSE_PERIOD(LP))
    i_phy_power_mgmt_eee_tx_lpi (.*);
  rgmii_mac_model i_rgmii_mac_model (.gclk_out(gtx_clk_in), .ctl_out(tx_ctl_in),
    .txd_out(txd_in));

  always #5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      end_of_test();
    end
  end
  // ==========================================================
  // helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // twelve cycles sit well inside both wake limits
  task automatic st();
    repeat (12) @(posedge mclk_in);
    chk(32'({chip_powerdown_out, soft_powerdown_out, energy_detect_sleep_out, ten_te_out,
      tx_lpi_out, rx_lpi_out}), 32'({m_chp, m_sft, m_slp, m_te, m_tx, m_rx}));
  endtask : st
  task automatic rst(input logic [3:0] s);
    reset_n_in <= 1'h0;
    mode_strap_in <= s;
    repeat (12) @(posedge mclk_in);
    reset_n_in <= 1'h1;
    sh = '{CTRL_RESET, 32'h0, 32'h0, 32'h0};
    {m_sft, m_slp, m_te, m_tx, m_rx} = 5'h00;
    m_chp = (s == STRAP_CHIP_PD);
  endtask : rst
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    @(posedge mclk_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    fork
      begin
        do @(posedge mclk_in); while (s_axi_awready !== 1'h1);
        s_axi_awvalid <= 1'h0;
      end
      begin
        do @(posedge mclk_in); while (s_axi_wready !== 1'h1);
        s_axi_wvalid <= 1'h0;
      end
    join
    while (s_axi_bvalid !== 1'h1) @(posedge mclk_in);
    s_axi_bready <= 1'h0;
    chk(32'(s_axi_bresp), 32'(r));
    if (r === RESP_OKAY) sh[a[3:2]] = d & ~32'h200;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = RESP_OKAY);
    @(posedge mclk_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge mclk_in); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge mclk_in); while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, e);
    chk(32'(s_axi_rresp), 32'(r));
  endtask : rd
  task automatic tx(input logic [9:0] s, input int k = 1);
    repeat (k) i_rgmii_mac_model.sym(s[9], s[8], s[7:0]);
  endtask : tx
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  // ==========================================================
  // sequence
  initial begin
    rst(4'h0);
    rd(CTRL_ADDR, sh[0]);
    rd(EEE_ADV_ADDR, sh[1]);
    rd(SLEEP_CFG_ADDR, sh[2]);
    rd(8'h14, 32'h0, RESP_SLVERR);
    wr(STATUS_ADDR, 32'hFF, RESP_SLVERR);
    st();
    wr(SLEEP_CFG_ADDR, 32'h1);
    m_slp = 1;
    st();
    n = 0;
    repeat (2 * LP) @(posedge mclk_in) n += link_pulse_out;
    chk(n, 2);
    wr(CTRL_ADDR, 32'h0040);
    m_slp = 0;
    st();
    wr(CTRL_ADDR, CTRL_RESET);
    m_slp = 1;
    st();
    link_up_in <= 1'h1;
    m_slp = 0;
    st();
    wr(TEN_TE_ADDR, 32'h400);
    m_te = 1;
    st();
    tx(10'h101, 10);
    st();
    wr(EEE_ADV_ADDR, 32'h6);
    chk(32'(eee_active_out), 32'h0);
    wr(CTRL_ADDR, 32'h1240);
    st();
    chk(32'(eee_active_out), 32'h3);
    for (int k = 0; k < 10; k++) begin
      rnd = lfsr(rnd);
      tx({2'h2, rnd[7:0]});
      st();
      chk(32'(tx_symbol_out), 32'({2'h2, rnd[7:0]}));
      tx(10'h101, 10);
      m_tx = 1;
      st();
      v = 10'h101 ^ (10'h001 << k);
      tx(v);
      m_tx = 0;
      st();
    end
    tx(10'h101, 12);
    rx_lpi_in <= 1'h1;
    m_tx = 1;
    m_rx = 1;
    st();
    chk(32'(clk_stop_ok_out), 32'h1);
    n = 0;
    repeat (2 * RP) @(posedge mclk_in) n += refresh_out;
    chk(n, 2 * RL);
    tx(10'h2AA);
    m_tx = 0;
    st();
    rx_lpi_in <= 1'h0;
    m_rx = 0;
    wr(CTRL_ADDR, 32'h1000);
    rnd = lfsr(rnd);
    tx({2'h2, rnd[7:0]});
    st();
    chk(32'(tx_symbol_out), 32'({6'h20, rnd[3:0]}));
    tx(10'h1E1, 10);
    m_tx = 1;
    st();
    chk(32'(tx_symbol_out), 32'h101);
    tx(10'h1E0);
    m_tx = 0;
    st();
    wr(CTRL_ADDR, 32'h1800);
    m_sft = 1;
    m_te = 0;
    st();
    tx(10'h101, 10);
    st();
    rd(CTRL_ADDR, sh[0]);
    tx(10'h255);
    wr(CTRL_ADDR, 32'h1000);
    m_sft = 0;
    m_te = 1;
    st();
    rst(STRAP_CHIP_PD);
    st();
    rst(4'h0);
    st();
    end_of_test();
  end
endmodule : phy_power_mgmt_eee_tx_lpi_bench

// file: testbench/rgmii_mac_model.sv
`timescale 1ns/1ps
module rgmii_mac_model (
  // rgmii transmit pins
  output logic gclk_out,
  output logic ctl_out,
  output logic [3:0] txd_out
);
  initial begin
    gclk_out = 1'h0;
    ctl_out = 1'h0;
    txd_out = 4'h0;
  end
  // clock stands low between calls; data moves a quarter period off each edge
  task automatic sym(input logic en, input logic er, input logic [7:0] d);
    ctl_out <= en;
    txd_out <= d[3:0];
    #31.25 gclk_out <= 1'h1;
    #31.25 ctl_out <= en ^ er;
    txd_out <= d[7:4];
    #31.25 gclk_out <= 1'h0;
    #31.25;
  endtask : sym
endmodule : rgmii_mac_model
